// ### common/fdmc_defs.svh
/*
  Constants of the fault and diagnostic mode controller: fast channel
  code ranges, slow channel identifier and timing counts.
  Assumes a 100 MHz system clock.
*/
`ifndef FDMC_DEFS_SVH
`define FDMC_DEFS_SVH
`define FDMC_FC_INIT       12'h000  // Initialization value, no data yet
`define FDMC_FC_DATA_MAX   12'hff8  // Largest legal measurement value
`define FDMC_FC_FAULT_BASE 12'hff9  // First reserved fault code
`define FDMC_FC_FAULT_MAX  12'hfff  // Last reserved fault code
`define FDMC_FC_SEL_MAX    3'h6     // Highest fault code selector
`define FDMC_SDM_STATUS_ID 8'h01    // Slow channel status message id
`define FDMC_CMD_ENTRY     8'h5a    // Command state entry code, arbitrary
`define FDMC_CLK_NS        10       // Clock period in ns
`define FDMC_WDG_NS        20000    // Watchdog timeout in ns
`define FDMC_WDG_CYC       ((`FDMC_WDG_NS + `FDMC_CLK_NS - 1) / `FDMC_CLK_NS)
`endif

// ### common/fdmc_pkg.sv
/*
  Types of the fault and diagnostic mode controller.
  Assumes fdmc_defs.svh for the numeric constants.
*/
package fdmc_pkg;
  // Diagnostic state, one-hot
  typedef enum logic [2:0] {
    DIAG_NORMAL = 3'b001,
    DIAG_TEMP   = 3'b010,
    DIAG_STATIC = 3'b100
  } fdmc_diag_e;
  // Per check configuration
  typedef struct packed {
    logic        static_sel;  // Check belongs to static mode
    logic [2:0]  fc_sel;      // Fast channel code offset
    logic [1:0]  stat_map;    // Status nibble bits driven
    logic [11:0] sdm_code;    // Slow channel status code
  } fdmc_fault_cfg_s;
  // Fault messaging options
  typedef struct packed {
    logic fc;
    logic stat;
    logic sdm;
  } fdmc_msg_en_s;
  // Content handed to the frame serializer
  typedef struct packed {
    logic [11:0] fc_value;
    logic [1:0]  status_bits;
    logic [7:0]  sdm_id;
    logic [11:0] sdm_data;
  } fdmc_frame_s;
endpackage

// ### rtl/fdmc_top.sv
/*
  Fault handling and diagnostic mode control with a measurement FIFO.
  Assumes check results, frame ticks and one-wire commands come from
  logic on clk_sys; the pin driver resolves dout_o and dout_oe.
*/
`timescale 1ns/100ps
`include "fdmc_defs.svh"

module fdmc_fifo #(
  parameter int W = 12,
  parameter int D = 4
) (
  input  wire logic         clk_sys,   // System clock
  input  wire logic         reset,     // Synchronous reset
  input  wire logic         in_valid,  // Write request
  output logic              in_ready,  // Space available
  input  wire logic [W-1:0] in_data,   // Write data
  output logic              out_valid, // Data available
  input  wire logic         out_ready, // Read request
  output logic [W-1:0]      out_data   // Head word
);
  localparam int AW = $clog2(D);
  logic [W-1:0]  mem [D];      // Storage
  logic [AW-1:0] wp;           // Write pointer
  logic [AW-1:0] rp;           // Read pointer
  logic [AW:0]   cnt;          // Fill level
  wire           push = in_valid & in_ready;
  wire           pop  = out_valid & out_ready;
  assign in_ready  = (cnt != (AW+1)'(D));
  assign out_valid = (cnt != '0);
  assign out_data  = mem[rp];
  // Pointers wrap at the depth, which need not be a power of two
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      wp  <= '0;
      rp  <= '0;
      cnt <= '0;
    end else begin
      if (push) wp <= (wp == AW'(D-1)) ? '0 : wp + 1'b1;
      if (pop) rp <= (rp == AW'(D-1)) ? '0 : rp + 1'b1;
      cnt <= cnt + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
  // Storage write
  always_ff @(posedge clk_sys) begin
    if (push) mem[wp] <= in_data;
  end
endmodule // fdmc_fifo

// Overview of operation
// RQ1: Failing check enters its diagnostic mode
// RQ2: Two modes; each check assigned to one
// RQ3: Static mode halts measurement and conditioning
// RQ4: Static stops frames; pin high or released
// RQ5: Static: one-wire on, pages readable, entry command
// RQ6: Static watchdog restarts and clears status
// RQ7: Temporary mode keeps cycles and checks running
// RQ8: Temporary mode frames carry fault indication
// RQ9: Temporary: one-wire on; master overpowers pin
// RQ10: Leave temporary mode once fault gone
// RQ11: Only temporary checks are confirmation filtered
// RQ12: Up/down counter delays entry and exit
// RQ13: Values 4089..4095 never sent as data
// RQ14: Fast channel 0 until data available
// RQ15: Highest priority fault code on fast channel
// RQ16: Status bits follow configurable fault map
// RQ17: Slow channel id 01 carries status code
// RQ18: Slow channel carries highest priority code
// RQ19: Confirmed fault sent within two frames
// RQ20: Counter saturates; threshold enters, zero leaves
module fdmc_top
  import fdmc_pkg::*;
#(
  parameter int N  = 8,   // Supervised checks
  parameter int CW = 4,   // Confirmation counter width
  parameter int FD = 4    // Measurement FIFO depth
) (
  input  wire logic                        clk_sys,         // 100 MHz clock
  input  wire logic                        reset,           // Sync reset
  input  wire logic                        check_strobe,    // Check results valid
  input  wire logic [N-1:0]                fault_fail,      // Per check fail
  input  fdmc_pkg::fdmc_fault_cfg_s [N-1:0] fault_cfg,      // Per check setup
  input  fdmc_pkg::fdmc_msg_en_s           msg_en,          // Messaging options
  input  wire logic [CW-1:0]               conf_threshold,  // Confirmation count
  input  wire logic                        static_hiz,      // Release pin in static
  input  wire logic                        wdg_enable,      // Watchdog on
  input  wire logic                        meas_valid,      // Measurement strobe
  input  wire logic [11:0]                 meas_data,       // Conditioned value
  output logic                             meas_ready,      // FIFO space
  input  wire logic                        frame_tick,      // Frame start
  input  wire logic                        sent_level,      // Serializer level
  input  wire logic                        owi_cmd_valid,   // One-wire command
  input  wire logic [7:0]                  owi_cmd,         // Command code
  output fdmc_pkg::fdmc_frame_s            frame_out,       // Frame content
  output logic                             frame_valid,     // Frame content pulse
  output logic                             meas_run,        // Cycles may run
  output logic                             dout_o,          // Pin level
  output logic                             dout_oe,         // Pin driven
  output logic                             one_wire_port_en, // One-wire receive on
  output logic                             owi_pages_rd,    // Output pages readable
  output logic                             command_state,   // Command state reached
  output fdmc_pkg::fdmc_diag_e             diagnostic_state, // Mode
  output logic                             restart          // Watchdog restart pulse
);
  import fdmc_pkg::*;

  localparam int WDG = `FDMC_WDG_CYC;

  // Lowest index wins
  function automatic int prio_idx(input logic [N-1:0] v);
    prio_idx = 0;
    for (int i = N - 1; i >= 0; i--) begin
      if (v[i]) prio_idx = i;
    end
  endfunction

  logic [CW-1:0]  conf_cnt;     // Confirmation counter
  logic [N-1:0]   act;          // Temporary faults of latest failing strobe
  logic [15:0]    wdg_cnt;      // Watchdog counter
  logic [11:0]    last_data;    // Latest measurement sent
  logic           have_data;    // First value seen
  logic           fifo_valid;   // FIFO head valid
  logic [11:0]    fifo_data;    // FIFO head

  // Static checks bypass filtering entirely
  wire [N-1:0] static_mask;
  for (genvar g = 0; g < N; g++) begin : g_mask
    assign static_mask[g] = fault_cfg[g].static_sel;  // RQ2
  end
  wire         rst_all    = reset | restart;
  wire         is_static  = (diagnostic_state == DIAG_STATIC);
  wire         is_temp    = (diagnostic_state == DIAG_TEMP);
  wire         static_hit = check_strobe & |(fault_fail & static_mask);   // RQ11
  wire         temp_hit   = |(fault_fail & ~static_mask);
  wire         cnt_top    = (conf_cnt >= conf_threshold);
  wire [CW-1:0] next_cnt  = !check_strobe ? conf_cnt :
                            temp_hit ? (cnt_top ? conf_cnt : conf_cnt + 1'b1) :
                            (conf_cnt == '0 ? conf_cnt : conf_cnt - 1'b1);   // RQ20
  wire         enter_tmp  = check_strobe & temp_hit & (next_cnt >= conf_threshold);
  // A failing strobe never leaves, even with a zero threshold
  wire         leave_tmp  = check_strobe & !temp_hit & (next_cnt == '0);

  // Mode sequencing; static is left only by reset or watchdog
  always_ff @(posedge clk_sys) begin
    if (rst_all) begin
      diagnostic_state <= DIAG_NORMAL;
    end else begin
      case (diagnostic_state)
        DIAG_NORMAL: begin
          if (static_hit) diagnostic_state <= DIAG_STATIC;       // RQ1
          else if (enter_tmp) diagnostic_state <= DIAG_TEMP;     // RQ12
        end
        DIAG_TEMP: begin
          if (static_hit) diagnostic_state <= DIAG_STATIC;
          else if (leave_tmp) diagnostic_state <= DIAG_NORMAL;   // RQ10
        end
        DIAG_STATIC: diagnostic_state <= DIAG_STATIC;
        default: diagnostic_state <= DIAG_NORMAL;
      endcase
    end
  end

  // Filter keeps counting in temporary mode, frozen in static
  always_ff @(posedge clk_sys) begin
    if (rst_all) begin
      conf_cnt <= '0;
      act      <= '0;
    end else if (!is_static) begin
      conf_cnt <= next_cnt;                                      // RQ7
      if (check_strobe && temp_hit) act <= fault_fail & ~static_mask;
      else if (leave_tmp) act <= '0;
    end
  end

  // Watchdog counts only while halted in static mode
  always_ff @(posedge clk_sys) begin
    if (rst_all) wdg_cnt <= '0;
    else if (is_static && wdg_enable) wdg_cnt <= wdg_cnt + 1'b1;
  end
  assign restart = is_static & wdg_enable & (wdg_cnt == 16'(WDG - 1)); // RQ6

  // Halting cycles in static also stalls the measurement source
  assign meas_run = !is_static;                                  // RQ3
  // A frame start on the edge that enters static is dropped as well
  wire fifo_pop   = frame_tick & !is_static & !static_hit;
  fdmc_fifo #(.W(12), .D(FD)) u_fifo (
    .clk_sys   (clk_sys),
    .reset     (rst_all),
    .in_valid  (meas_valid & meas_run),
    .in_ready  (meas_ready),
    .in_data   (meas_data),
    .out_valid (fifo_valid),
    .out_ready (fifo_pop),
    .out_data  (fifo_data)
  );

  // Fault selection, decided from confirmed faults
  wire [N-1:0] top_vec   = is_temp ? act : '0;
  wire [2:0]   sel_raw   = fault_cfg[prio_idx(top_vec)].fc_sel;
  wire [2:0]   sel       = (sel_raw > `FDMC_FC_SEL_MAX) ? `FDMC_FC_SEL_MAX : sel_raw;
  wire [11:0]  fault_fc  = `FDMC_FC_FAULT_BASE + {9'h000, sel};            // RQ15
  wire [11:0]  sdm_code  = fault_cfg[prio_idx(top_vec)].sdm_code;         // RQ18
  // All options off would hide the fault, so the fast channel stands in
  wire         fc_on     = msg_en.fc | ~(msg_en.stat | msg_en.sdm);       // RQ8
  wire [11:0]  cur_data  = fifo_valid ? fifo_data : last_data;
  wire         cur_have  = fifo_valid | have_data;
  wire [11:0]  data_fc   = (cur_data > `FDMC_FC_DATA_MAX) ? `FDMC_FC_DATA_MAX
                         : cur_data;                                      // RQ13
  logic [1:0]  stat_or;
  always_comb begin
    stat_or = 2'b00;
    for (int i = 0; i < N; i++) begin
      if (top_vec[i]) stat_or = stat_or | fault_cfg[i].stat_map;          // RQ16
    end
  end
  wire [11:0]  next_fc   = (is_temp && fc_on) ? fault_fc :
                           !cur_have ? `FDMC_FC_INIT : data_fc;           // RQ14

  // Frame content refreshed at every frame start outside static mode and its entry edge
  always_ff @(posedge clk_sys) begin
    if (rst_all) begin
      frame_out   <= '0;
      frame_valid <= 1'b0;
      last_data   <= '0;
      have_data   <= 1'b0;
    end else begin
      frame_valid <= fifo_pop;                                   // RQ4
      if (fifo_valid && fifo_pop) begin
        last_data <= fifo_data;
        have_data <= 1'b1;
      end
      if (fifo_pop) begin
        frame_out.fc_value    <= next_fc;                        // RQ19
        frame_out.status_bits <= msg_en.stat ? stat_or : 2'b00;
        frame_out.sdm_id      <= `FDMC_SDM_STATUS_ID;            // RQ17
        frame_out.sdm_data    <= (is_temp && msg_en.sdm) ? sdm_code : 12'h000;
      end
    end
  end

  // Pin: static drives high or releases; else serializer level
  assign dout_o  = is_static ? 1'b1 : sent_level;                // RQ4
  assign dout_oe = is_static ? !static_hiz : 1'b1;
  // Receiver listens in every mode; master overpowers the driven level
  assign one_wire_port_en = 1'b1;                                // RQ9
  assign owi_pages_rd     = is_static;                           // RQ5

  // Command state entered only by the entry command
  always_ff @(posedge clk_sys) begin
    if (rst_all) command_state <= 1'b0;
    else if (owi_cmd_valid && owi_cmd == `FDMC_CMD_ENTRY) command_state <= 1'b1; // RQ5
  end

  property p_static_halt;
    @(posedge clk_sys) disable iff (reset) is_static |-> !meas_run && !frame_valid;
  endproperty
  a_static_halt: assert property (p_static_halt) else $error("static not halted"); // RQ3
  property p_static_pin;
    @(posedge clk_sys) disable iff (reset)
      is_static |-> (dout_oe == !static_hiz) && dout_o;
  endproperty
  a_static_pin: assert property (p_static_pin) else $error("static pin wrong"); // RQ4
  property p_static_now;
    @(posedge clk_sys) disable iff (reset) static_hit && !restart |=> is_static;
  endproperty
  a_static_now: assert property (p_static_now) else $error("static filtered"); // RQ11
  property p_wdg;
    @(posedge clk_sys) disable iff (reset) restart |=> diagnostic_state == DIAG_NORMAL
      && conf_cnt == '0 && !command_state;
  endproperty
  a_wdg: assert property (p_wdg) else $error("watchdog restart failed"); // RQ6
  property p_enter;
    @(posedge clk_sys) disable iff (rst_all)
      diagnostic_state == DIAG_NORMAL && !static_hit && enter_tmp |=> is_temp;
  endproperty
  a_enter: assert property (p_enter) else $error("no temporary entry"); // RQ12
  property p_leave;
    @(posedge clk_sys) disable iff (rst_all)
      is_temp && !static_hit && check_strobe && !temp_hit && conf_cnt == 1
      |=> diagnostic_state == DIAG_NORMAL;
  endproperty
  a_leave: assert property (p_leave) else $error("no return to normal"); // RQ10
  property p_fault_frame;
    @(posedge clk_sys) disable iff (rst_all) is_temp && fc_on && frame_tick && !static_hit
      |=> frame_valid && frame_out.fc_value >= `FDMC_FC_FAULT_BASE;
  endproperty
  a_fault_frame: assert property (p_fault_frame) else $error("fault not framed"); // RQ19
  property p_data_range;
    @(posedge clk_sys) disable iff (rst_all) frame_valid && !$past(is_temp)
      |-> frame_out.fc_value <= `FDMC_FC_DATA_MAX;
  endproperty
  a_data_range: assert property (p_data_range) else $error("reserved value as data"); // RQ13
  // Nothing measured yet: the frame carries the initialization value
  property p_init;
    @(posedge clk_sys) disable iff (rst_all) frame_valid && !$past(is_temp) && !$past(cur_have)
      |-> frame_out.fc_value == `FDMC_FC_INIT;
  endproperty
  a_init: assert property (p_init) else $error("no initialization value"); // RQ14
  property p_sdm_id;
    @(posedge clk_sys) disable iff (reset) frame_valid |-> frame_out.sdm_id == 8'h01;
  endproperty
  a_sdm_id: assert property (p_sdm_id) else $error("status id wrong"); // RQ17
  c_temp:   cover property (@(posedge clk_sys) is_temp ##[1:200] !is_temp && !is_static);
  c_static: cover property (@(posedge clk_sys) static_hit ##1 is_static);
  c_full:   cover property (@(posedge clk_sys) !meas_ready);
  // Watchdog restart out of static
  c_restart: cover property (@(posedge clk_sys) restart);
endmodule // fdmc_top

// ### verif/fdmc_ecu_model.sv
/*
  Behavioural far side: receiver of frames on the output line, plus the
  one-wire master that shares the line. Assumes everything on clk_sys.
*/
`timescale 1ns/100ps
`include "fdmc_defs.svh"

module fdmc_ecu_model
  import fdmc_pkg::*;
(
  input  wire logic             clk_sys,       // System clock
  input  wire logic             reset,         // Sync reset
  input  fdmc_pkg::fdmc_frame_s frame_out,     // Frame content
  input  wire logic             frame_valid,   // Frame strobe
  input  wire logic             dout_o,        // Pin level
  input  wire logic             dout_oe,       // Pin driven
  input  wire logic             send_entry,    // Master asked to send entry
  output fdmc_pkg::fdmc_frame_s last,          // Last frame received
  output logic [15:0]           frame_cnt,     // Frames received
  output logic                  pin,           // Resolved line level
  output logic                  owi_cmd_valid, // Master command pulse
  output logic [7:0]            owi_cmd        // Master command code
);
  // Load pull-up lifts a released line
  assign pin = dout_oe ? dout_o : 1'b1;
  // Frame capture, counted so the bench can wait on it
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      frame_cnt <= 16'h0000;
      last      <= '0;
    end else if (frame_valid) begin
      frame_cnt <= frame_cnt + 16'h0001;
      last      <= frame_out;
    end
  end
  // Entry command on request; sent as a code only, the line is not driven
  always_ff @(posedge clk_sys) begin
    owi_cmd_valid <= send_entry;
    // Idle code is the inverse, so a stale value never looks valid
    owi_cmd       <= send_entry ? `FDMC_CMD_ENTRY : ~`FDMC_CMD_ENTRY;
  end
endmodule // fdmc_ecu_model

// ### verif/testbench.sv
/*
  Self-checking bench of the fault and diagnostic mode controller.
  Assumes fdmc_pkg, fdmc_defs.svh and the far side model.
*/
`timescale 1ns/100ps
`include "fdmc_defs.svh"

module testbench;
  import fdmc_pkg::*;
  logic clk_sys = 1'b0, reset = 1'b1, check_strobe = 1'b0, static_hiz = 1'b0;
  logic wdg_enable = 1'b0, meas_valid = 1'b0, frame_tick = 1'b0, sent_level = 1'b0;
  logic send_entry = 1'b0, meas_ready, frame_valid, meas_run, dout_o, dout_oe;
  logic one_wire_port_en, owi_pages_rd, command_state, restart, pin, owi_cmd_valid;
  logic [7:0]       fault_fail = 8'h00;  // Per check fail
  logic [3:0]       conf_threshold = 4'h2; // Two confirmations
  logic [11:0]      meas_data = 12'h000; // Measurement word
  logic [7:0]       owi_cmd;             // Master command
  logic [15:0]      frame_cnt;           // Frames at receiver
  fdmc_fault_cfg_s [7:0] fault_cfg;      // Per check setup
  fdmc_msg_en_s     msg_en = 3'b111;     // All messaging on
  fdmc_frame_s      frame_out, last;     // Frame content
  fdmc_diag_e       diagnostic_state;    // Mode
  int n_fail = 0, checks_done = 0;       // Counters
  always #5 clk_sys = ~clk_sys;          // 100 MHz
  fdmc_top #(.N(8), .CW(4), .FD(4)) dut_u (.clk_sys(clk_sys), .reset(reset),
    .check_strobe(check_strobe), .fault_fail(fault_fail), .fault_cfg(fault_cfg),
    .msg_en(msg_en), .conf_threshold(conf_threshold), .static_hiz(static_hiz),
    .wdg_enable(wdg_enable), .meas_valid(meas_valid), .meas_data(meas_data),
    .meas_ready(meas_ready), .frame_tick(frame_tick), .sent_level(sent_level),
    .owi_cmd_valid(owi_cmd_valid), .owi_cmd(owi_cmd), .frame_out(frame_out),
    .frame_valid(frame_valid), .meas_run(meas_run), .dout_o(dout_o), .dout_oe(dout_oe),
    .one_wire_port_en(one_wire_port_en), .owi_pages_rd(owi_pages_rd),
    .command_state(command_state), .diagnostic_state(diagnostic_state),
    .restart(restart));
  fdmc_ecu_model ecu_u (.clk_sys(clk_sys), .reset(reset), .frame_out(frame_out),
    .frame_valid(frame_valid), .dout_o(dout_o), .dout_oe(dout_oe),
    .send_entry(send_entry), .last(last), .frame_cnt(frame_cnt), .pin(pin),
    .owi_cmd_valid(owi_cmd_valid), .owi_cmd(owi_cmd));
  // Single comparison point; four-state safe
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_fail++;
      $display("unexpected %s: expected %h seen %h", nm, exp, seen);
    end
  endtask
  // Verdict and end of run
  task automatic summarize();
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // One check strobe and one idle cycle, so back to back strobes stay apart
  task automatic strobe(input logic [7:0] f);
    check_strobe = 1'b1;
    fault_fail   = f;
    @(negedge clk_sys);
    check_strobe = 1'b0;
    @(negedge clk_sys);
  endtask
  // One measurement write
  task automatic push(input logic [11:0] v);
    meas_valid = 1'b1;
    meas_data  = v;
    @(negedge clk_sys);
    meas_valid = 1'b0;
    @(negedge clk_sys);
  endtask
  // One frame start, waits for the receiver under a bound
  task automatic frame();
    logic [15:0] c0;
    c0 = frame_cnt;
    frame_tick = 1'b1;
    @(negedge clk_sys);
    frame_tick = 1'b0;
    for (int k = 0; k < 4 && frame_cnt == c0; k++) @(negedge clk_sys);
  endtask
  // Reset values and initial fast channel content
  task automatic t_reset();
    chk("state", diagnostic_state, DIAG_NORMAL);
    chk("run", {meas_run, dout_oe, one_wire_port_en, command_state}, 4'b1110);
    sent_level = 1'b1;
    @(negedge clk_sys);
    chk("pin high", {pin, dout_o}, 2'b11);
    sent_level = 1'b0;
    @(negedge clk_sys);
    chk("pin low", {pin, dout_o}, 2'b00);
    frame();
    chk("fc init", last.fc_value, `FDMC_FC_INIT);
    chk("sdm id", last.sdm_id, `FDMC_SDM_STATUS_ID);
    $display("test reset done");
  endtask
  // FIFO filled while the receiver stalls, then drained; reserved values
  task automatic t_fifo();
    logic [11:0] v [4] = '{12'h123, 12'hff9, 12'hfff, 12'h000};
    for (int i = 0; i < 4; i++) push(v[i]);
    chk("full", meas_ready, 1'b0);
    push(12'h777);
    for (int i = 0; i < 4; i++) begin
      frame();
      chk("fc data", last.fc_value, (v[i] > 12'hff8) ? 12'hff8 : v[i]);
    end
    chk("ready", meas_ready, 1'b1);
    $display("test fifo done");
  endtask
  // Confirmation filter, priority and messaging in temporary mode
  task automatic t_temp();
    strobe(8'h24);
    chk("one fail", diagnostic_state, DIAG_NORMAL);
    strobe(8'h24);
    chk("confirmed", diagnostic_state, DIAG_TEMP);
    chk("run temp", {meas_run, dout_oe}, 2'b11);
    push(12'h456);
    frame();
    chk("fc code", last.fc_value, `FDMC_FC_FAULT_BASE + 12'h002);
    chk("status", last.status_bits, 2'b11);
    chk("sdm code", last.sdm_data, 12'h0a2);
    send_entry = 1'b1;
    @(negedge clk_sys);
    send_entry = 1'b0;
    repeat (2) @(negedge clk_sys);
    chk("cmd state", command_state, 1'b1);
    strobe(8'h00);
    chk("one pass", diagnostic_state, DIAG_TEMP);
    strobe(8'h00);
    chk("exit", diagnostic_state, DIAG_NORMAL);
    push(12'h456);
    frame();
    chk("fc back", last.fc_value, 12'h456);
    chk("sdm clear", last.sdm_data, 12'h000);
    $display("test temporary done");
  endtask
  // All messaging off: fast channel stands in; selector 7 clamps to last code
  task automatic t_msg();
    msg_en = '0;
    strobe(8'h80);
    strobe(8'h80);
    chk("temp again", diagnostic_state, DIAG_TEMP);
    frame();
    chk("fc fallback", last.fc_value, `FDMC_FC_FAULT_MAX);
    chk("status off", last.status_bits, 2'b00);
    chk("sdm off", last.sdm_data, 12'h000);
    strobe(8'h00);
    strobe(8'h00);
    chk("normal again", diagnostic_state, DIAG_NORMAL);
    msg_en = 3'b111;
    frame();
    chk("fc hold", last.fc_value, 12'h456);
    $display("test messaging done");
  endtask
  // Static mode, pin options and watchdog restart
  task automatic t_static();
    logic [15:0] c0;
    int n;
    strobe(8'h21);
    chk("static", diagnostic_state, DIAG_STATIC);
    chk("halt", meas_run, 1'b0);
    chk("ow", {one_wire_port_en, owi_pages_rd}, 2'b11);
    chk("pin drive", {pin, dout_oe}, 2'b11);
    static_hiz = 1'b1;
    #1 chk("pin hiz", {pin, dout_oe}, 2'b10);
    c0 = frame_cnt;
    frame();
    chk("no frame", frame_cnt, c0);
    wdg_enable = 1'b1;
    for (n = 0; n < 2100 && restart !== 1'b1; n++) @(negedge clk_sys);
    chk("wdg time", (n >= `FDMC_WDG_CYC - 2) && (n <= `FDMC_WDG_CYC + 1), 1'b1);
    @(negedge clk_sys);
    chk("restarted", {diagnostic_state, command_state}, {DIAG_NORMAL, 1'b0});
    $display("test static done");
  endtask
  // Main sequence
  initial begin
    for (int i = 0; i < 8; i++)
      fault_cfg[i] = '{1'b0, 3'(i), 2'b00, 12'h0a0 + 12'(i)};
    fault_cfg[0].static_sel = 1'b1;
    fault_cfg[2].stat_map   = 2'b01;
    fault_cfg[5].stat_map   = 2'b10;
    fault_cfg[7].stat_map   = 2'b11;
    repeat (5) @(negedge clk_sys);
    reset = 1'b0;
    t_reset();
    t_fifo();
    t_temp();
    t_msg();
    t_static();
    summarize();
  end
  // Hang guard
  initial begin
    #200000;
    n_fail++;
    summarize();
  end
endmodule // testbench
